//--- hdl/dac_serial_command_slave.sv
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module dac_serial_command_slave
    import dac_cmd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n_o,
    input  wire logic        addr_sel_i,
    output logic [VAL_W-1:0] conv_value_o,
    output logic [1:0]       pwrdn_sel_o,
    output logic             out_float_o,
    output logic             out_1k_o,
    output logic             out_100k_o,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest
);
    // ==========================================================
    // Pin synchronisers and edge detection
    logic [1:0] pin_s;
    sync2 #(.W(2)) u_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    ({scl_i, sda_i}),
        .q_o    (pin_s)
    );
    logic scl_d_reg, sda_d_reg;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= pin_s[1];
            sda_d_reg <= pin_s[0];
        end
    end
    // Strap pin is asynchronous as well
    logic strap_s;
    sync2 #(.W(1)) u_sync_strap (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (addr_sel_i),
        .q_o    (strap_s)
    );
    wire scl_rise = pin_s[1] & ~scl_d_reg;
    wire scl_fall = ~pin_s[1] & scl_d_reg;
    wire start_c  = pin_s[1] & scl_d_reg & sda_d_reg & ~pin_s[0];
    wire stop_c   = pin_s[1] & scl_d_reg & ~sda_d_reg & pin_s[0];

    // ==========================================================
    // Control register (software address override)
    logic [5:0] addr_hi_reg;

    // ==========================================================
    // Protocol state machine
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_CMD  = 6'b000100,
        ST_DATA = 6'b001000,
        ST_TX   = 6'b010000,
        ST_GATE = 6'b100000
    } st_e;
    st_e        st_reg;
    logic [3:0] bit_reg;
    logic [7:0] sh_reg;
    logic       ack_reg, rd_byte_reg, rd_ack_ok_reg;
    logic [7:0] cmd_reg;
    logic [VAL_W-1:0] hold_reg, conv_reg;
    logic [1:0] pd_reg;
    wire  [7:0] sh_next = {sh_reg[6:0], pin_s[0]};
    wire  [6:0] my_addr = {addr_hi_reg, strap_s};

    function automatic logic addr_ok(input logic [7:0] b, input logic [6:0] a);
        addr_ok = (b[7:1] == a) && (b[7:1] != GEN_CALL)
                  && (b[7:3] != TEN_BIT_PFX);
    endfunction

    // Bit counter and shifter: bit 0..7 sampled on rising, 8 is acknowledge
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            bit_reg <= '0;
            sh_reg  <= '0;
        end else if (start_c) begin
            bit_reg <= '1;  // First fall after START is no data bit
        end else if (st_reg != ST_IDLE && st_reg != ST_GATE) begin
            if (scl_rise && bit_reg <= BIT_LAST)
                sh_reg <= sh_next;
            if (scl_fall)
                bit_reg <= (bit_reg == BIT_ACK) ? 4'h0 : bit_reg + 4'h1;
        end
    end

    // State and register updates
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            st_reg        <= ST_IDLE;
            ack_reg       <= 1'b0;
            rd_byte_reg   <= 1'b0;
            rd_ack_ok_reg <= 1'b0;
            cmd_reg       <= '0;
            hold_reg      <= '0;
            conv_reg      <= '0;
            pd_reg        <= PD_RESET;
        end else if (start_c) begin
            st_reg  <= ST_ADDR;
            ack_reg <= 1'b0;
        end else if (stop_c) begin
            st_reg  <= ST_IDLE;
            ack_reg <= 1'b0;
        end else if (scl_fall) begin
            case (st_reg)
                ST_ADDR: begin
                    if (bit_reg == BIT_LAST) begin
                        if (addr_ok(sh_reg, my_addr)) begin
                            ack_reg <= 1'b1;
                        end else begin
                            st_reg <= ST_GATE;
                        end
                    end else if (bit_reg == BIT_ACK) begin
                        ack_reg     <= 1'b0;
                        rd_byte_reg <= 1'b0;
                        st_reg      <= sh_reg[0] ? ST_TX : ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (bit_reg == BIT_LAST) begin
                        ack_reg <= 1'b1;
                        cmd_reg <= sh_reg;
                    end else if (bit_reg == BIT_ACK) begin
                        ack_reg <= 1'b0;
                        st_reg  <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (bit_reg == BIT_LAST) begin
                        ack_reg <= 1'b1;
                    end else if (bit_reg == BIT_ACK) begin
                        // Commit on falling edge of acknowledge clock
                        ack_reg <= 1'b0;
                        st_reg  <= ST_CMD;
                        case (cmd_reg[7:4])
                            CMD_LOAD_UPD: begin
                                hold_reg <= {cmd_reg[3:0], sh_reg};
                                conv_reg <= {cmd_reg[3:0], sh_reg};
                            end
                            CMD_LOAD_IN:  hold_reg <= {cmd_reg[3:0], sh_reg};
                            CMD_LOAD_SWP: begin
                                hold_reg <= {cmd_reg[3:0], sh_reg};
                                conv_reg <= hold_reg;
                            end
                            CMD_UPD:      conv_reg <= hold_reg;
                            default: begin
                                if (cmd_reg[7:6] == CMD_PD_TOP)
                                    pd_reg <= cmd_reg[3:2];
                                // Read request 10xx changes nothing
                            end
                        endcase
                    end
                end
                ST_TX: begin
                    if (bit_reg == BIT_LAST) begin
                        rd_ack_ok_reg <= 1'b1;
                    end else if (bit_reg == BIT_ACK) begin
                        rd_byte_reg <= ~rd_byte_reg;
                        if (!rd_ack_ok_reg || rd_byte_reg)
                            st_reg <= ST_GATE;
                    end
                end
                ST_IDLE, ST_GATE: ;
                default: st_reg <= ST_IDLE;
            endcase
        end else if (scl_rise && st_reg == ST_TX && bit_reg == BIT_ACK) begin
            rd_ack_ok_reg <= ~pin_s[0];
        end
    end

    // Transmit bit: first byte 0000 + value 11:8, then value 7:0
    wire [7:0] tx_byte = rd_byte_reg ? conv_reg[7:0]
                                     : {4'h0, conv_reg[VAL_W-1:8]};
    wire       tx_low  = (st_reg == ST_TX) && (bit_reg <= BIT_LAST)
                         && !tx_byte[3'(BIT_LAST - bit_reg)];

    // ==========================================================
    // Pin and output flops
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sda_oe_n_o   <= 1'b1;
            sda_o        <= 1'b0;
            conv_value_o <= '0;
            pwrdn_sel_o  <= PD_RESET;
            out_float_o  <= 1'b0;
            out_1k_o     <= 1'b0;
            out_100k_o   <= 1'b1;
        end else begin
            sda_oe_n_o   <= ~(ack_reg | tx_low);
            sda_o        <= 1'b0;
            conv_value_o <= conv_reg;
            pwrdn_sel_o  <= pd_reg;
            out_float_o  <= (pd_reg == PD_FLOAT);
            out_1k_o     <= (pd_reg == PD_1K);
            out_100k_o   <= (pd_reg == PD_100K);
        end
    end

    // ==========================================================
    // Avalon-MM slave: one wait cycle on every access
    logic ack_bus_reg;
    wire  req = avs_read | avs_write;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ack_bus_reg     <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
            addr_hi_reg     <= ADDR_HI_DEF;
        end else begin
            ack_bus_reg     <= req & ~ack_bus_reg;
            avs_waitrequest <= ~(req & ~ack_bus_reg);
            if (req && !ack_bus_reg) begin
                if (avs_write && avs_address == OFS_CTRL)
                    addr_hi_reg <= avs_writedata[5:0];
                case (avs_address)
                    OFS_CONV: avs_readdata <= {20'h0_0000, conv_reg};
                    OFS_HOLD: avs_readdata <= {20'h0_0000, hold_reg};
                    OFS_PD:   avs_readdata <= {30'h0000_0000, pd_reg};
                    OFS_CTRL: avs_readdata <= {26'h000_0000, addr_hi_reg};
                    default:  avs_readdata <= BAD_DATA;
                endcase
            end
        end
    end

    // ==========================================================
    // Assertions
    property p_gate_quiet;
        @(posedge clk_i) disable iff (!nrst_i)
        (st_reg == ST_GATE && !start_c) |=> $stable(conv_reg) && $stable(hold_reg);
    endproperty
    a_gate_quiet: assert property (p_gate_quiet) else $error("activity while gated");
    property p_start_wakes;
        @(posedge clk_i) disable iff (!nrst_i) start_c |=> st_reg == ST_ADDR;
    endproperty
    a_start_wakes: assert property (p_start_wakes) else $error("start not honoured");
    property p_pd_decode;
        @(posedge clk_i) disable iff (!nrst_i)
        ##1 out_1k_o == ($past(pd_reg) == PD_1K) && out_float_o == ($past(pd_reg) == PD_FLOAT);
    endproperty
    a_pd_decode: assert property (p_pd_decode) else $error("power-down decode wrong");
    property p_stop_keeps;
        @(posedge clk_i) disable iff (!nrst_i) stop_c |=> $stable(conv_reg) && $stable(pd_reg);
    endproperty
    a_stop_keeps: assert property (p_stop_keeps) else $error("stop changed data");
    property p_ack_drive;
        @(posedge clk_i) disable iff (!nrst_i) ack_reg |=> !sda_oe_n_o;
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("no ack drive");
    property p_update_at_ack;
        @(posedge clk_i) disable iff (!nrst_i)
        !$stable(conv_reg) |-> $past(scl_fall) && $past(bit_reg) == BIT_ACK;
    endproperty
    a_update_at_ack: assert property (p_update_at_ack) else $error("update off ack");
    property p_nack_ends;
        @(posedge clk_i) disable iff (!nrst_i)
        (st_reg == ST_TX && scl_fall && bit_reg == BIT_ACK && !rd_ack_ok_reg && !start_c
         && !stop_c) |=> st_reg == ST_GATE;
    endproperty
    a_nack_ends: assert property (p_nack_ends) else $error("sent past nack");
    property p_bus_wait;
        @(posedge clk_i) disable iff (!nrst_i)
        ($rose(avs_read) && avs_waitrequest) |=> !avs_waitrequest;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus answer late");
    // Address byte end and what must follow it
    sequence s_addr_end;
        st_reg == ST_ADDR && scl_fall && bit_reg == BIT_LAST && !start_c && !stop_c;
    endsequence
    sequence s_ack_out;
        ack_reg ##1 !sda_oe_n_o;
    endsequence
    property p_addr_ack;
        @(posedge clk_i) disable iff (!nrst_i)
        s_addr_end ##0 addr_ok(sh_reg, my_addr) |=> s_ack_out;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
    property p_addr_gate;
        @(posedge clk_i) disable iff (!nrst_i)
        s_addr_end ##0 !addr_ok(sh_reg, my_addr) |=> st_reg == ST_GATE && !ack_reg;
    endproperty
    a_addr_gate: assert property (p_addr_gate) else $error("mismatch not gated");
    property p_no_gen_call;
        @(posedge clk_i) disable iff (!nrst_i)
        s_addr_end ##0 sh_reg[7:1] == GEN_CALL |=> !ack_reg;
    endproperty
    a_no_gen_call: assert property (p_no_gen_call) else $error("gen call answered");
    property p_no_ten_bit;
        @(posedge clk_i) disable iff (!nrst_i)
        s_addr_end ##0 sh_reg[7:3] == TEN_BIT_PFX |=> !ack_reg;
    endproperty
    a_no_ten_bit: assert property (p_no_ten_bit) else $error("ten-bit answered");
    property p_read_turn;
        @(posedge clk_i) disable iff (!nrst_i)
        (st_reg == ST_ADDR && scl_fall && bit_reg == BIT_ACK && sh_reg[0]
         && !start_c && !stop_c) |=> st_reg == ST_TX && !rd_byte_reg;
    endproperty
    a_read_turn: assert property (p_read_turn) else $error("no turnaround");
endmodule // dac_serial_command_slave
`default_nettype wire

//--- hdl/dac_cmd_pkg.sv
// What this block does
// - Command 1100 loads holding and converter registers; output updates immediately.
// - Command 1101 loads only the holding register; converter register unchanged.
// - Command 1110 loads holding register, old holding value moves to converter.
// - Command 1111 copies holding into converter; data bits discarded.
// - Top command bits 10 request read-back; data ignored, converter value offered.
// - Top command bits 01 write data bits 11:10 into power-down select.
// - Power-down select: 00 normal, 01 floating, 10 1k, 11 100k to ground.
// - Read-direction address makes device drive converter register onto data line.
// - Data line turns around right after address acknowledge in a read.
// - Device sends first byte, waits for master acknowledge, then second byte.
// - As receiver, device pulls data low during ninth clock of each byte.
// - General call address is never acknowledged.
// - Only 7-bit addressing; ten-bit formats get no answer.
// - Address mismatch gates serial clock away from core logic.
// - Serial clock path restored only on a valid START condition.
// - Address: six upper bits from the control register (default ADDR_HI_DEF) plus strap pin as lowest bit.
// - Address byte lowest bit: 0 master writes, 1 master reads.
// - Registers update on falling serial clock edge during acknowledge.
// - Cut-short write leaves registers unchanged; master repeats write.
package dac_cmd_pkg;
    localparam int          VAL_W        = 12;
    localparam logic [5:0]  ADDR_HI_DEF  = 6'h04;
    localparam logic [6:0]  GEN_CALL     = 7'h00;
    localparam logic [4:0]  TEN_BIT_PFX  = 5'h1e;
    localparam logic [3:0]  CMD_LOAD_UPD = 4'hc;
    localparam logic [3:0]  CMD_LOAD_IN  = 4'hd;
    localparam logic [3:0]  CMD_LOAD_SWP = 4'he;
    localparam logic [3:0]  CMD_UPD      = 4'hf;
    localparam logic [1:0]  CMD_READ_TOP = 2'h2;
    localparam logic [1:0]  CMD_PD_TOP   = 2'h1;
    localparam logic [1:0]  PD_NORMAL    = 2'h0;
    localparam logic [1:0]  PD_FLOAT     = 2'h1;
    localparam logic [1:0]  PD_1K        = 2'h2;
    localparam logic [1:0]  PD_100K      = 2'h3;
    localparam logic [1:0]  PD_RESET     = 2'h3;
    localparam logic [3:0]  BIT_LAST     = 4'h7;
    localparam logic [3:0]  BIT_ACK      = 4'h8;
    // Avalon-MM register offsets (byte addresses)
    localparam logic [3:0]  OFS_CONV     = 4'h0;
    localparam logic [3:0]  OFS_HOLD     = 4'h4;
    localparam logic [3:0]  OFS_PD       = 4'h8;
    localparam logic [3:0]  OFS_CTRL     = 4'hc;
    localparam logic [31:0] BAD_DATA     = 32'hdead_beef;
endpackage : dac_cmd_pkg

//--- hdl/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 2
) (
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            meta_reg <= '1;
            q_o      <= '1;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule // sync2
`default_nettype wire

//--- verif/i2c_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Two-wire master, open drain, line pulled up when released
module i2c_master_model (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // One bit: 25 clocks, 125 ns; data changes only while clock is low
    task automatic bit_cyc(input logic v, output logic r);
        @(posedge clk_i);
        sda_o <= v;
        repeat (11) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        r = sda_i;
        repeat (7) @(posedge clk_i);
        scl_o <= 1'b0;
    endtask
    task automatic start_cond;
        @(posedge clk_i);
        sda_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (12) @(posedge clk_i);
        sda_o <= 1'b0;
        repeat (12) @(posedge clk_i);
        scl_o <= 1'b0;
    endtask
    task automatic stop_cond;
        @(posedge clk_i);
        sda_o <= 1'b0;
        repeat (12) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (12) @(posedge clk_i);
        sda_o <= 1'b1;
        repeat (12) @(posedge clk_i);
    endtask
    // Master releases the line for the ninth bit
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_cyc(b[i], r);
        bit_cyc(1'b1, ack);
    endtask
    // Master answers each byte, device waits for it
    task automatic rd_byte(input logic m_ack, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, r);
            b[i] = r;
        end
        bit_cyc(m_ack, r);
    endtask
endmodule // i2c_master_model
`default_nettype wire

//--- verif/dac_serial_command_slave_test.sv
`timescale 1ns/1ps
`default_nettype none
module dac_serial_command_slave_test
    import dac_cmd_pkg::*;
;
    logic        clk_i, nrst_i, scl, sda_m, sda_w, addr_sel, sda_o, sda_oe_n;
    logic [11:0] conv;
    logic [1:0]  pd;
    logic        fl, k1, k100;
    logic [3:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [5:0]  addr_hi;
    int          hold_m, conv_m, pd_m, num_errors, check_count;
    assign sda_w = sda_m & (sda_oe_n | sda_o);
    dac_serial_command_slave u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .addr_sel_i(addr_sel),
        .conv_value_o(conv), .pwrdn_sel_o(pd), .out_float_o(fl), .out_1k_o(k1),
        .out_100k_o(k100), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    i2c_master_model u_mst (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
    // ======================================================
    // Checking and bus tasks
    task automatic complete_run;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        @(posedge clk_i);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20) begin
            num_errors++;
            complete_run();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic regs_chk;
        chk(32'(conv), conv_m);
        av(1'b0, OFS_HOLD, 32'h0000_0000);
        chk(q, hold_m);
        chk(32'(pd), pd_m);
        chk(32'({fl, k1, k100}), (pd_m == 0) ? 0 : (8 >> pd_m));
    endtask
    task automatic wr_cmd(input logic [3:0] c, input logic [11:0] d, input bit full);
        logic ack;
        u_mst.start_cond();
        u_mst.wr_byte({addr_hi, addr_sel, 1'b0}, ack);
        chk(32'(ack), 0);
        u_mst.wr_byte({c, d[11:8]}, ack);
        chk(32'(ack), 0);
        if (full) begin
            u_mst.wr_byte(d[7:0], ack);
            chk(32'(ack), 0);
            case (c)
                4'hc: begin hold_m = d; conv_m = d; end
                4'hd: hold_m = d;
                4'he: begin conv_m = hold_m; hold_m = d; end
                4'hf: conv_m = hold_m;
                default: if (c[3:2] == CMD_PD_TOP) pd_m = d[11:10];
            endcase
        end
        u_mst.stop_cond();
        regs_chk();
    endtask
    task automatic rd_cmd;
        logic       ack;
        logic [7:0] b;
        u_mst.start_cond();
        u_mst.wr_byte({addr_hi, addr_sel, 1'b1}, ack);
        chk(32'(ack), 0);
        u_mst.rd_byte(1'b0, b);
        chk(32'(b), conv_m >> 8);
        u_mst.rd_byte(1'b1, b);
        chk(32'(b), conv_m & 255);
        u_mst.stop_cond();
    endtask
    task automatic bad_addr(input logic [7:0] a);
        logic ack;
        u_mst.start_cond();
        u_mst.wr_byte(a, ack);
        chk(32'(ack), 1);
        u_mst.wr_byte(8'hc5, ack);
        u_mst.wr_byte(8'h5a, ack);
        u_mst.stop_cond();
        regs_chk();
    endtask
    // ======================================================
    // Clock, watchdog and main sequence
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (90000) @(posedge clk_i);
        num_errors++;
        complete_run();
    end
    initial begin
        nrst_i = 1'b0;
        addr_sel = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        addr_hi = ADDR_HI_DEF;
        {hold_m, conv_m, pd_m, num_errors, check_count} = {32'd0, 32'd0, 32'd3, 64'd0};
        void'($urandom(11733));
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        regs_chk();
        av(1'b0, OFS_CTRL, 32'h0000_0000);
        chk(q, 32'(ADDR_HI_DEF));
        av(1'b0, 4'h2, 32'h0000_0000);
        chk(q, BAD_DATA);
        av(1'b1, OFS_CONV, 32'h0000_0abc);
        regs_chk();
        for (int r = 0; r < 8; r++) begin
            wr_cmd({2'b11, 2'(r)}, 12'($urandom), 1'b1);
            rd_cmd();
        end
        for (int p = 0; p < 4; p++) wr_cmd({2'b01, 2'($urandom)}, {2'(p), 10'($urandom)}, 1'b1);
        wr_cmd({CMD_READ_TOP, 2'($urandom)}, 12'($urandom), 1'b1);
        addr_sel <= 1'b1;
        bad_addr({ADDR_HI_DEF, 2'b00});
        av(1'b1, OFS_CTRL, 32'h0000_0000);
        addr_sel <= 1'b0;
        bad_addr(8'h00);
        av(1'b1, OFS_CTRL, 32'h0000_003c);
        bad_addr({TEN_BIT_PFX, 3'b000});
        av(1'b1, OFS_CTRL, 32'(ADDR_HI_DEF));
        addr_sel <= 1'b1;
        wr_cmd(CMD_LOAD_UPD, 12'($urandom), 1'b0);
        wr_cmd(CMD_LOAD_UPD, 12'($urandom), 1'b1);
        av(1'b1, OFS_CTRL, 32'h0000_002a);
        addr_hi = 6'h2a;
        wr_cmd(CMD_LOAD_SWP, 12'($urandom), 1'b1);
        rd_cmd();
        complete_run();
    end
endmodule // dac_serial_command_slave_test
`default_nettype wire
